// File: core/cbc_pkg.sv
/*
 * Shared constants and carrier types of the clock buffer control block:
 * register indices, reset values, write masks, field positions, bus types.
 * Assumes an AXI4-Lite master with 32-bit data and byte addressing.
 */
package cbc_pkg;

	// Bus geometry
	localparam int          ADDR_W      = 8;
	localparam int          IDX_W       = 6;

	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_RST     = 6'h00;
	localparam logic [5:0]  IDX_SEQ     = 6'h02;
	localparam logic [5:0]  IDX_CHN     = 6'h03;
	localparam logic [5:0]  IDX_OBA     = 6'h04;
	localparam logic [5:0]  IDX_OPB     = 6'h05;
	localparam logic [5:0]  IDX_OPC     = 6'h06;

	// Values after reset
	localparam logic [15:0] RST_RST     = 16'h0000;
	localparam logic [15:0] RST_SEQ     = 16'h0223;
	localparam logic [15:0] RST_CHN     = 16'hff86;
	localparam logic [15:0] RST_OBA     = 16'h360f;
	localparam logic [15:0] RST_OPB     = 16'h4936;
	localparam logic [15:0] RST_OPC     = 16'h36d4; // Ch3 ref level 4

	// Writable bits; the rest read as zero
	localparam logic [15:0] MSK_RST     = 16'h0007;
	localparam logic [15:0] MSK_SEQ     = 16'h07ff;
	localparam logic [15:0] MSK_CHN     = 16'hffff;
	localparam logic [15:0] MSK_OBA     = 16'h3fff;
	localparam logic [15:0] MSK_OPB     = 16'h7fff;
	localparam logic [15:0] MSK_OPC     = 16'hffff;

	// Field positions
	localparam int          SRST_BIT    = 0;
	localparam int          PD_BIT      = 2;
	localparam int          GATE_BIT    = 5;
	localparam int          PRE_LSB     = 6;
	localparam int          EXP_LSB     = 0;
	localparam int          SIL_LSB     = 7;
	localparam int          AUXSIL_BIT  = 11;
	localparam int          CHEN_LSB    = 12;
	localparam int          CLKEN_LSB   = 0;
	localparam int          REFEN_LSB   = 4;
	localparam int          CLKLVL_A    = 8;
	localparam int          CLKLVL_B    = 0;
	localparam int          REFLVL_B    = 6;
	localparam int          REFLVL_C    = 0;

	// Prescale codes
	localparam logic [3:0]  PRE_D2      = 4'h2;
	localparam logic [3:0]  PRE_D4      = 4'h4;
	localparam logic [3:0]  PRE_D8      = 4'h8;

	// Bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} cbc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cbc_axi_rsp_t;

	typedef struct packed {
		logic        low_power;
		logic        seq_gate;
		logic        seq_tick;
		logic [3:0]  chan_on;
		logic [3:0]  clk_on;
		logic [3:0]  ref_on;
		logic [11:0] clk_lvl;
		logic [11:0] ref_lvl;
		logic        aux_silence;
	} cbc_ctrl_t;

endpackage : cbc_pkg

// File: core/cbc_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes address and data in either order,
 * hands one word write or read to the register bank, then answers.
 * Assumes the bank answers hit and read data combinationally.
 */
`timescale 1ns/100ps
module cbc_axil_slave (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire cbc_pkg::cbc_axi_req_t axi_req,
	output      cbc_pkg::cbc_axi_rsp_t axi_rsp,
	output      logic                 wr_en,
	output      logic [5:0]           wr_idx,
	output      logic [15:0]          wr_data,
	output      logic [1:0]           wr_strb,
	input  wire logic                 wr_hit,
	output      logic [5:0]           rd_idx,
	input  wire logic [15:0]          rd_data,
	input  wire logic                 rd_hit
);
	import cbc_pkg::*;

	typedef struct packed {
		cbc_axi_rsp_t rsp;
		logic         aw_ok;
		logic         w_ok;
		logic         ar_ok;
		logic [5:0]   widx;
		logic [5:0]   ridx;
		logic [15:0]  wdata;
		logic [1:0]   wstrb;
	} cbc_slv_st_t;

	cbc_slv_st_t s_r;
	cbc_slv_st_t s_nxt;

	// Handshakes and answers
	always_comb begin
		s_nxt = s_r;
		wr_en = 1'b0;
		if (axi_req.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_ok       = 1'b1;
			s_nxt.widx        = axi_req.awaddr[ADDR_W-1:2];
			s_nxt.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && s_r.rsp.wready) begin
			s_nxt.w_ok       = 1'b1;
			s_nxt.wdata      = axi_req.wdata[15:0];
			s_nxt.wstrb      = axi_req.wstrb[1:0];
			s_nxt.rsp.wready = 1'b0;
		end
		if (s_r.aw_ok && s_r.w_ok && !s_r.rsp.bvalid) begin
			wr_en            = 1'b1;
			s_nxt.aw_ok      = 1'b0;
			s_nxt.w_ok       = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.rsp.bvalid && axi_req.bready) begin
			s_nxt.rsp.bvalid  = 1'b0;
			s_nxt.rsp.awready = 1'b1;
			s_nxt.rsp.wready  = 1'b1;
		end
		if (axi_req.arvalid && s_r.rsp.arready) begin
			s_nxt.ar_ok       = 1'b1;
			s_nxt.ridx        = axi_req.araddr[ADDR_W-1:2];
			s_nxt.rsp.arready = 1'b0;
		end
		if (s_r.ar_ok) begin
			s_nxt.ar_ok      = 1'b0;
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata  = {16'h0000, rd_data};
			s_nxt.rsp.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.rsp.rvalid && axi_req.rready) begin
			s_nxt.rsp.rvalid  = 1'b0;
			s_nxt.rsp.arready = 1'b1;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r             <= '0;
			s_r.rsp.awready <= 1'b1;
			s_r.rsp.wready  <= 1'b1;
			s_r.rsp.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign axi_rsp = s_r.rsp;
	assign wr_idx  = s_r.widx;
	assign wr_data = s_r.wdata;
	assign wr_strb = s_r.wstrb;
	assign rd_idx  = s_r.ridx;

endmodule : cbc_axil_slave

// File: core/cbc_regs.sv
/*
 * Clock buffer control register bank: soft reset, low power, sequencer
 * clock divider chain, channel enables, calibration silencing, output
 * buffer enables and output levels, reached over AXI4-Lite.
 * Assumes cal_active comes from another domain; it is synchronised here.
 */
// Chosen here: the AXI4-Lite register port.
// How it works
// - Writing one to offset 0 bit 0 resets all; clears on next mapped write.
// - Offset 0 bit 2 enters low power; other registers are kept.
// - Read-only reserved bits read zero and ignore writes.
// - Prescale field divides by 2, 4 or 8; resets to code 8.
// - Divide exponent field divides by two to its value; resets to 6.
// - Offset 2 bit 5 gates the sequencer clock; resets to one.
// - Channel enables at offset 3 bits 15:12 reset to one, kill channel.
// - Offset 3 bits 11:7 silence outputs during calibration; reset one.
// - Frame reference buffer enables, offset 4 bits 7:4, reset zero.
// - Clock buffer enables, offset 4 bits 3:0, reset one.
// - Clock output level fields reset to 6; larger means more power.
// - Frame reference levels for channels 2..0 at offset 5, reset 4.
// - Channel three frame reference level, offset 6 bits 2:0, reset 4.
`timescale 1ns/100ps
module cbc_regs #(
	parameter int CNT_W = 11
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire cbc_pkg::cbc_axi_req_t axi_req,
	output      cbc_pkg::cbc_axi_rsp_t axi_rsp,
	input  wire logic                  cal_active,
	output      cbc_pkg::cbc_ctrl_t    ctrl
);
	import cbc_pkg::*;

	// The longest divide is 8 times 128
	if (CNT_W < 11) begin : g_chk
		$error("CNT_W must be at least 11");
	end

	typedef struct packed {
		logic [15:0]      rst_pd;
		logic [15:0]      seq_pre;
		logic [15:0]      chn_ctl;
		logic [15:0]      obuf_a;
		logic [15:0]      olvl_b;
		logic [15:0]      olvl_c;
		logic [CNT_W-1:0] cnt;
		logic             cal_ff1;
		logic             cal_ff2;
		cbc_ctrl_t        ctrl;
	} cbc_bank_st_t;

	cbc_bank_st_t s_r;
	cbc_bank_st_t s_nxt;

	logic         wr_en;
	logic [5:0]   wr_idx;
	logic [15:0]  wr_data;
	logic [1:0]   wr_strb;
	logic         wr_hit;
	logic [5:0]   rd_idx;
	logic [15:0]  rd_data;
	logic         rd_hit;

	logic         pd;
	logic [3:0]   ch_on;
	logic [3:0]   clk_on;
	logic [3:0]   ref_on;
	logic [11:0]  clk_all;
	logic [11:0]  ref_all;

	// Bus front end
	cbc_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_hit  (wr_hit),
		.rd_idx  (rd_idx),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	// True for offsets that hold a register
	function automatic logic mapped(input logic [5:0] idx);
		logic hit;
		hit = 1'b0;
		case (idx)
			IDX_RST, IDX_SEQ, IDX_CHN,
			IDX_OBA, IDX_OPB, IDX_OPC: hit = 1'b1;
			default:                   hit = 1'b0;
		endcase
		return hit;
	endfunction : mapped

	// Byte-lane merge, then read-only bits forced to zero
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [15:0] d,
		input logic [1:0]  st,
		input logic [15:0] m
	);
		logic [15:0] v;
		v = old;
		if (st[0]) begin
			v[7:0] = d[7:0];
		end
		if (st[1]) begin
			v[15:8] = d[15:8];
		end
		return v & m;
	endfunction : merge

	// Cycle count of one sequencer period
	function automatic logic [CNT_W-1:0] period(
		input logic [3:0] code,
		input logic [2:0] expo
	);
		logic [CNT_W-1:0] pre;
		case (code)
			PRE_D2:  pre = CNT_W'(2);
			PRE_D4:  pre = CNT_W'(4);
			default: pre = CNT_W'(8);
		endcase
		return pre << expo;
	endfunction : period

	assign wr_hit = mapped(wr_idx);
	assign rd_hit = mapped(rd_idx);

	// Read mux; stored words already hold zero in read-only bits
	always_comb begin
		case (rd_idx)
			IDX_RST: rd_data = s_r.rst_pd;
			IDX_SEQ: rd_data = s_r.seq_pre;
			IDX_CHN: rd_data = s_r.chn_ctl;
			IDX_OBA: rd_data = s_r.obuf_a;
			IDX_OPB: rd_data = s_r.olvl_b;
			IDX_OPC: rd_data = s_r.olvl_c;
			default: rd_data = 16'h0000;
		endcase
	end

	assign pd      = s_r.rst_pd[PD_BIT];
	assign clk_all = {s_r.olvl_b[CLKLVL_B +: 6], s_r.obuf_a[CLKLVL_A +: 6]};
	assign ref_all = {s_r.olvl_c[REFLVL_C +: 3], s_r.olvl_b[REFLVL_B +: 9]};

	// Per-channel enables after low power, channel kill and silencing
	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic mute;
		assign mute      = s_r.cal_ff2 & s_r.chn_ctl[SIL_LSB+i];
		assign ch_on[i]  = s_r.chn_ctl[CHEN_LSB+i] & ~pd;
		assign clk_on[i] = ch_on[i] & ~mute
			& s_r.obuf_a[CLKEN_LSB+i];
		assign ref_on[i] = ch_on[i] & ~mute
			& s_r.obuf_a[REFEN_LSB+i];
	end

	// Register writes, soft reset, divider and output staging
	always_comb begin
		logic [15:0] r0_base;
		r0_base = s_r.rst_pd;
		r0_base[SRST_BIT] = 1'b0;
		s_nxt = s_r;

		// Calibration flag synchroniser
		s_nxt.cal_ff1 = cal_active;
		s_nxt.cal_ff2 = s_r.cal_ff1;

		// Sequencer clock: counts only while gated on and awake
		if (!s_r.seq_pre[GATE_BIT] || pd) begin
			s_nxt.cnt           = '0;
			s_nxt.ctrl.seq_tick = 1'b0;
		end else if (s_r.cnt == '0) begin
			s_nxt.cnt = period(s_r.seq_pre[PRE_LSB +: 4],
				s_r.chn_ctl[EXP_LSB +: 3]) - CNT_W'(1);
			s_nxt.ctrl.seq_tick = 1'b1;
		end else begin
			s_nxt.cnt           = s_r.cnt - CNT_W'(1);
			s_nxt.ctrl.seq_tick = 1'b0;
		end

		// Outputs staged into flip-flops
		s_nxt.ctrl.low_power   = pd;
		s_nxt.ctrl.seq_gate    = s_r.seq_pre[GATE_BIT] & ~pd;
		s_nxt.ctrl.chan_on     = ch_on;
		s_nxt.ctrl.clk_on      = clk_on;
		s_nxt.ctrl.ref_on      = ref_on;
		s_nxt.ctrl.clk_lvl     = clk_all;
		s_nxt.ctrl.ref_lvl     = ref_all;
		s_nxt.ctrl.aux_silence = s_r.cal_ff2
			& s_r.chn_ctl[AUXSIL_BIT] & ~pd;

		// Any mapped write first drops a pending soft reset flag
		if (wr_en && wr_hit) begin
			s_nxt.rst_pd = r0_base;
			if (wr_idx == IDX_RST && wr_strb[0] && wr_data[SRST_BIT]) begin
				// Soft reset: every register and the divider restart
				s_nxt.rst_pd           = RST_RST;
				s_nxt.rst_pd[SRST_BIT] = 1'b1;
				s_nxt.seq_pre          = RST_SEQ;
				s_nxt.chn_ctl          = RST_CHN;
				s_nxt.obuf_a           = RST_OBA;
				s_nxt.olvl_b           = RST_OPB;
				s_nxt.olvl_c           = RST_OPC;
				s_nxt.cnt              = '0;
				s_nxt.ctrl.seq_tick    = 1'b0;
			end else begin
				case (wr_idx)
					IDX_RST: begin
						s_nxt.rst_pd = merge(r0_base, wr_data,
							wr_strb, MSK_RST);
					end
					IDX_SEQ: begin
						s_nxt.seq_pre = merge(s_r.seq_pre, wr_data,
							wr_strb, MSK_SEQ);
					end
					IDX_CHN: begin
						s_nxt.chn_ctl = merge(s_r.chn_ctl, wr_data,
							wr_strb, MSK_CHN);
					end
					IDX_OBA: begin
						s_nxt.obuf_a = merge(s_r.obuf_a, wr_data,
							wr_strb, MSK_OBA);
					end
					IDX_OPB: begin
						s_nxt.olvl_b = merge(s_r.olvl_b, wr_data,
							wr_strb, MSK_OPB);
					end
					IDX_OPC: begin
						s_nxt.olvl_c = merge(s_r.olvl_c, wr_data,
							wr_strb, MSK_OPC);
					end
					default: begin
						s_nxt.rst_pd = r0_base;
					end
				endcase
			end
		end
	end

	// State register with power-on values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r         <= '0;
			s_r.rst_pd  <= RST_RST;
			s_r.seq_pre <= RST_SEQ;
			s_r.chn_ctl <= RST_CHN;
			s_r.obuf_a  <= RST_OBA;
			s_r.olvl_b  <= RST_OPB;
			s_r.olvl_c  <= RST_OPC;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ctrl = s_r.ctrl;

endmodule : cbc_regs

// File: test/cbc_regs_monitor.sv
/* Port checker for cbc_regs, bound at the foot.
   Assumes the host offers write address and data together. */
`timescale 1ns/100ps
module cbc_regs_monitor import cbc_pkg::*; #(
	parameter int CNT_W = 11
) (
	input wire cbc_pkg::cbc_axi_req_t axi_req,
	input wire cbc_pkg::cbc_axi_rsp_t axi_rsp,
	input wire cbc_pkg::cbc_ctrl_t    ctrl,
	input wire logic                  cal_active,
	input wire logic                  aclk,
	input wire logic                  aresetn
);
	import cbc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus takes
	wire logic aw_go = axi_req.awvalid & axi_rsp.awready
		& axi_req.wvalid & axi_rsp.wready;
	wire logic ar_go = axi_req.arvalid & axi_rsp.arready;
	// Bus answers
	property p_wr_lat;
		aw_go |-> ##2 axi_rsp.bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("late write");
	property p_unmap;
		aw_go && axi_req.awaddr == 8'h04 |-> ##2 axi_rsp.bresp == RESP_SLVERR;
	endproperty
	a_unmap: assert property (p_unmap) else $error("no slverr");
	property p_rd_lat;
		ar_go |-> ##2 axi_rsp.rvalid && axi_rsp.rdata[31:16] == 16'h0000;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("bad read");
	// Control outputs
	property p_lp;
		ctrl.low_power |-> ctrl.chan_on == 4'h0 && !ctrl.seq_gate;
	endproperty
	a_lp: assert property (p_lp) else $error("low power leak");
	property p_chan;
		((ctrl.clk_on | ctrl.ref_on) & ~ctrl.chan_on) == 4'h0;
	endproperty
	a_chan: assert property (p_chan) else $error("dead channel on");
	property p_tick;
		!ctrl.seq_gate [*4] |-> !ctrl.seq_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick gated");
	property p_pulse;
		$rose(ctrl.seq_tick) |=> !ctrl.seq_tick;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long tick");
	property p_mute;
		ctrl.aux_silence |-> $past(cal_active, 3);
	endproperty
	a_mute: assert property (p_mute) else $error("stray mute");
endmodule : cbc_regs_monitor

bind cbc_regs cbc_regs_monitor #(.CNT_W(CNT_W)) u_mon (.aclk(aclk),
	.aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.cal_active(cal_active), .ctrl(ctrl));

// File: test/cbc_regs_tb.sv
/* Self-checking bench for cbc_regs over AXI4-Lite.
   Assumes the answer latencies given with the design. */
`timescale 1ns/100ps
module cbc_regs_tb;
	import cbc_pkg::*;
	typedef struct packed {
		logic        w;
		logic [5:0]  i;
		logic [15:0] d;
		logic [15:0] e;
	} cbc_row_t;
	logic          aclk;
	logic          aresetn;
	logic          cal_active;
	cbc_axi_req_t  req;
	cbc_axi_rsp_t  axi_rsp;
	cbc_ctrl_t     ctrl;
	int            n_mismatch;
	int            samples_checked;
	logic [31:0]   q;
	logic [1:0]    r;
	int            n;
	cbc_row_t      rows [11];
	logic [3:0]    pc [4] = '{4'h2, 4'h4, 4'h8, 4'h2};
	logic [2:0]    pe [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
	int            pp [4] = '{2, 8, 32, 256};

	cbc_regs dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
		.axi_rsp(axi_rsp), .cal_active(cal_active), .ctrl(ctrl));

	// Clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task settle(input int c);
		repeat (c) @(posedge aclk);
		@(negedge aclk);
	endtask : settle

	task wr(input logic [5:0] i, input logic [15:0] d, output logic [1:0] rs);
		logic pa, pw, pb, a, w, b;
		@(posedge aclk);
		req.awaddr <= {i, 2'b00};
		req.wdata <= {16'h0000, d};
		req.wstrb <= 4'hf;
		{req.awvalid, req.wvalid, req.bready} <= 3'h7;
		{pa, pw, pb} = 3'h7;
		while (pb) begin
			@(negedge aclk);
			a = axi_rsp.awready & pa;
			w = axi_rsp.wready & pw;
			b = axi_rsp.bvalid & ~pa & ~pw;
			rs = axi_rsp.bresp;
			@(posedge aclk);
			if (a) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
			if (b) req.bready <= 1'b0;
			pa = pa & ~a;
			pw = pw & ~w;
			pb = pb & ~b;
		end
	endtask : wr

	task rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] rs);
		logic pa, pr, a, b;
		@(posedge aclk);
		req.araddr <= {i, 2'b00};
		{req.arvalid, req.rready} <= 2'h3;
		{pa, pr} = 2'h3;
		while (pr) begin
			@(negedge aclk);
			a = axi_rsp.arready & pa;
			b = axi_rsp.rvalid & ~pa;
			{d, rs} = {axi_rsp.rdata, axi_rsp.rresp};
			@(posedge aclk);
			if (a) req.arvalid <= 1'b0;
			if (b) req.rready <= 1'b0;
			pa = pa & ~a;
			pr = pr & ~b;
		end
	endtask : rd

	// Gap between two sequencer ticks
	task tk(output int c);
		repeat (2) begin
			do @(negedge aclk); while (ctrl.seq_tick !== 1'b1);
		end
		c = 0;
		do begin
			@(negedge aclk);
			c++;
		end while (ctrl.seq_tick !== 1'b1);
	endtask : tk

	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		rows = '{
			'{1'b0, IDX_RST, 16'h0, RST_RST}, '{1'b0, IDX_SEQ, 16'h0, RST_SEQ},
			'{1'b0, IDX_CHN, 16'h0, RST_CHN}, '{1'b0, IDX_OBA, 16'h0, RST_OBA},
			'{1'b0, IDX_OPB, 16'h0, RST_OPB}, '{1'b1, IDX_OPB, 16'hffff, 16'h7fff},
			'{1'b1, IDX_OBA, 16'hffff, 16'h3fff}, '{1'b1, IDX_OPC, 16'h1234, 16'h1234},
			'{1'b1, IDX_SEQ, 16'hfbe3, 16'h03e3}, '{1'b1, IDX_CHN, 16'h0001, 16'h0001},
			'{1'b1, IDX_RST, 16'hfff8, 16'h0000}};
		n_mismatch = 0;
		samples_checked = 0;
		req = '0;
		cal_active = 1'b0;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		settle(2);
		chk(ctrl.clk_on, 4'hf);
		chk(ctrl.ref_on, 4'h0);
		chk(ctrl.chan_on, 4'hf);
		chk(ctrl.clk_lvl, 12'hdb6);
		chk(ctrl.ref_lvl[8:0], 9'h124);
		chk(ctrl.ref_lvl[11:9], 3'h4);
		rd(IDX_OPC, q, r);
		chk(q[2:0], 3'h4);
		chk(ctrl.seq_gate, 1'b1);
		// Table of reads and writes
		for (int k = 0; k < 11; k++) begin
			if (rows[k].w) wr(rows[k].i, rows[k].d, r);
			rd(rows[k].i, q, r);
			chk(q, rows[k].e);
			chk(r, RESP_OKAY);
		end
		// Soft reset and its self clear
		wr(IDX_RST, 16'h0001, r);
		rd(IDX_RST, q, r);
		chk(q, 16'h0001);
		rd(IDX_OPB, q, r);
		chk(q, RST_OPB);
		wr(IDX_SEQ, RST_SEQ, r);
		rd(IDX_RST, q, r);
		chk(q, 16'h0000);
		// Low power keeps registers
		wr(IDX_RST, 16'h0004, r);
		settle(1);
		chk(ctrl.chan_on, 4'h0);
		chk(ctrl.low_power, 1'b1);
		chk(ctrl.clk_lvl, 12'hdb6);
		rd(IDX_OBA, q, r);
		chk(q, RST_OBA);
		wr(IDX_RST, 16'h0000, r);
		// Channel kill and buffer enables
		wr(IDX_CHN, 16'hef86, r);
		wr(IDX_OBA, 16'h36ff, r);
		settle(1);
		chk(ctrl.clk_on, 4'he);
		chk(ctrl.ref_on, 4'he);
		// Silence during calibration, channel 0 exempt
		cal_active <= 1'b1;
		wr(IDX_CHN, 16'hff06, r);
		settle(1);
		chk(ctrl.clk_on, 4'h1);
		chk(ctrl.aux_silence, 1'b1);
		cal_active <= 1'b0;
		// Unmapped offset
		wr(6'h01, 16'hffff, r);
		chk(r, RESP_SLVERR);
		rd(6'h01, q, r);
		chk(q, 32'h0);
		chk(r, RESP_SLVERR);
		// Divider chain periods
		for (int k = 0; k < 4; k++) begin
			wr(IDX_CHN, {13'h1ff0, pe[k]}, r);
			wr(IDX_SEQ, {6'h00, pc[k], 6'h23}, r);
			tk(n);
			chk(n, pp[k]);
		end
		// Gate off stops ticks
		wr(IDX_SEQ, 16'h0203, r);
		n = 0;
		repeat (600) begin
			@(negedge aclk);
			if (ctrl.seq_tick === 1'b1) n++;
		end
		chk(n, 0);
		chk(ctrl.seq_gate, 1'b0);
		// Reset again in mid-run
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle(2);
		chk(ctrl.clk_on, 4'hf);
		rd(IDX_SEQ, q, r);
		chk(q, RST_SEQ);
		print_verdict();
	end
endmodule : cbc_regs_tb
